// ---- core/slsl_pkg.sv ----
// Shared constants and types for the strap latch and speed indicator block.
package slsl_pkg;
  // Register offsets (five-bit management register index).
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STRAP = 5'h10;
  localparam logic [4:0] REG_IND = 5'h1E;
  // Field positions.
  localparam int SPD_BIT = 13;
  localparam int IND_LO = 14;
  localparam int STRAP_IF_LO = 8;
  localparam int ADDR_W = 5;
  localparam int PINS = 7;
  // Pin indices within the strap pin vector.
  localparam int PIN_SPD = 0;
  localparam int PIN_AD0 = 1;
  localparam int PIN_IF0 = 4;
  // Reset values, equal to the internal pull defaults.
  localparam logic RST_SPD = 1'b1;
  localparam logic [2:0] RST_ADDR = 3'h1;
  localparam logic [2:0] RST_IFSEL = 3'h0;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] ADDR_HI = 2'h0;
  // Indicator modes.
  localparam logic [1:0] IND_SPEED = 2'h0;
  localparam logic [1:0] IND_ACT = 2'h1;
  // Interface-select codes.
  localparam logic [2:0] IFS_MII = 3'h0;
  localparam logic [2:0] IFS_RMII = 3'h1;
  localparam logic [2:0] IFS_MII_PRE = 3'h4;
  // Blink timing: half period of the activity blink.
  localparam int CLK_MHZ = 25;
  localparam int BLINK_HALF_US = 1000;
  localparam int BLINK_CYCLES = BLINK_HALF_US * CLK_MHZ;
  localparam int BLINK_W = 16;

  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } slsl_state_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } slsl_bus_t;

  typedef struct packed {
    logic mii;
    logic rmii;
    logic mii_pre;
    logic reserved;
  } slsl_ifmode_t;

  typedef struct packed {
    slsl_state_t st;
    logic spd;
    logic [1:0] mode;
    logic [2:0] addr;
    logic [2:0] ifsel;
    logic blink;
    logic [BLINK_W-1:0] cnt;
    logic led;
    logic [15:0] rdata;
  } slsl_regs_t;
endpackage : slsl_pkg

// ---- core/slsl_pad.sv ----
// Dual-role strap pin cell: input during reset and capture, driven output afterwards.
`timescale 1ns/1ps
module slsl_pad (
  input wire logic run,     // High once straps are captured
  input wire logic drive,   // Function value for the pin
  output logic pin_o,       // Pin output value
  output logic pin_oe       // Pin output enable, high while driven
);
  // While not running the pin floats so the board pull sets the strap level.
  assign pin_oe = run;
  assign pin_o = run & drive;
endmodule : slsl_pad

// ---- core/slsl_core.sv ----
// Strap capture at reset release and programmable speed/activity indicator.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module slsl_core import slsl_pkg::*; #(
  parameter int BLINK_HALF = BLINK_CYCLES
) (
  input wire logic CLK,                     // 25 MHz clock
  input wire logic RST_N,                   // Asynchronous active-low chip reset
  input wire logic [PINS-1:0] STRAP_I,      // Strap pin input levels
  output logic [PINS-1:0] STRAP_O,          // Strap pin output values
  output logic [PINS-1:0] STRAP_OE,         // Strap pin output enables
  input wire logic [PINS-2:0] FUNC_O,       // Run-time values of the non-indicator pins
  input wire logic ACTIVITY,                // Link activity level
  input wire slsl_bus_t REG_REQ,            // Register request
  output logic [15:0] REG_RDATA,            // Read data, cycle after read strobe
  output logic [ADDR_W-1:0] MGMT_ADDR,      // Management station address
  output slsl_ifmode_t IF_MODE,             // Decoded MAC interface mode
  output logic SPEED_100                    // Speed select, high for 100 Mbit/s
);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF - 1);

  slsl_regs_t r_reg;
  slsl_regs_t r_next;
  logic [PINS-1:0] pin_drive;
  logic running;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  always_comb begin
    r_next = r_reg;
    r_next.rdata = 16'h0000;
    case (r_reg.st)
      ST_CAPTURE: begin
        r_next.spd = STRAP_I[PIN_SPD];
        r_next.addr = STRAP_I[PIN_AD0 +: 3];
        r_next.ifsel = STRAP_I[PIN_IF0 +: 3];
        r_next.st = ST_RUN;
      end
      ST_RUN: begin
        if (REG_REQ.wr) begin
          if (REG_REQ.addr == REG_CTRL) begin
            r_next.spd = REG_REQ.wdata[SPD_BIT];
          end
          if (REG_REQ.addr == REG_IND) begin
            r_next.mode = REG_REQ.wdata[IND_LO +: 2];
          end
        end
        if (REG_REQ.rd) begin
          case (REG_REQ.addr)
            REG_CTRL: r_next.rdata[SPD_BIT] = r_reg.spd;
            REG_IND: r_next.rdata[IND_LO +: 2] = r_reg.mode;
            REG_STRAP: begin
              r_next.rdata[STRAP_IF_LO +: 3] = r_reg.ifsel;
              r_next.rdata[ADDR_W-1:0] = {ADDR_HI, r_reg.addr};
            end
            default: r_next.rdata = 16'h0000;
          endcase
        end
      end
      default: r_next.st = ST_CAPTURE;
    endcase
    // Blink counter runs only during activity, so idle always restarts a full half period.
    if (ACTIVITY) begin
      if (r_reg.cnt == BLINK_LAST) begin
        r_next.cnt = '0;
        r_next.blink = ~r_reg.blink;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end else begin
      r_next.cnt = '0;
      r_next.blink = 1'b1;
    end
    case (r_reg.mode)
      IND_SPEED: r_next.led = ~r_reg.spd;
      IND_ACT: r_next.led = ACTIVITY ? r_reg.blink : 1'b1;
      default: r_next.led = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_reg <= '{st: ST_CAPTURE, spd: RST_SPD, mode: RST_MODE, addr: RST_ADDR,
                 ifsel: RST_IFSEL, blink: 1'b1, cnt: '0, led: 1'b1, rdata: 16'h0000};
    end else begin
      r_reg <= r_next;
    end
  end

  assign running = (r_reg.st == ST_RUN);
  assign pin_drive = {FUNC_O, r_reg.led};

  for (genvar i = 0; i < PINS; i++) begin : g_pad
    slsl_pad u_pad (
      .run(running),
      .drive(pin_drive[i]),
      .pin_o(STRAP_O[i]),
      .pin_oe(STRAP_OE[i])
    );
  end

  assign MGMT_ADDR = {ADDR_HI, r_reg.addr};
  assign IF_MODE.mii = (r_reg.ifsel == IFS_MII);
  assign IF_MODE.rmii = (r_reg.ifsel == IFS_RMII);
  assign IF_MODE.mii_pre = (r_reg.ifsel == IFS_MII_PRE);
  assign IF_MODE.reserved = ~(IF_MODE.mii | IF_MODE.rmii | IF_MODE.mii_pre);
  assign SPEED_100 = r_reg.spd;
  assign REG_RDATA = r_reg.rdata;

  // Strap pin direction and the one-cycle capture sequence.
  a_pins_float: assert property (r_reg.st == ST_CAPTURE |-> STRAP_OE == '0)
    else $error("Strap pin driven during capture.");
  a_pin_low: assert property (!running |-> STRAP_O == '0)
    else $error("Strap pin value not parked low while floating.");
  a_oe_all: assert property (running |-> &STRAP_OE)
    else $error("Strap pin left floating while running.");
  a_pin_func: assert property (running |-> STRAP_O[PINS-1:1] == FUNC_O)
    else $error("Run-time pin value not passed through.");
  a_capture_run: assert property (r_reg.st == ST_CAPTURE |=> running && (&STRAP_OE))
    else $error("Capture not followed by run with pins driven.");
  a_capture_once: assert property (running |=> running)
    else $error("Left run state without a reset.");
  a_cfg_hold: assert property (running |=> $stable(MGMT_ADDR) && $stable(r_reg.ifsel))
    else $error("Latched strap configuration changed while running.");

  // Speed select: latched from the strap, then owned by software.
  a_spd_latch: assert property (r_reg.st == ST_CAPTURE
                                |=> SPEED_100 == $past(STRAP_I[PIN_SPD]))
    else $error("Speed select not latched from strap.");
  a_spd_write: assert property (running && REG_REQ.wr && REG_REQ.addr == REG_CTRL
                                |=> SPEED_100 == $past(REG_REQ.wdata[SPD_BIT]))
    else $error("Speed select write lost.");
  a_spd_keep: assert property (running && !(REG_REQ.wr && REG_REQ.addr == REG_CTRL)
                               |=> $stable(SPEED_100))
    else $error("Speed select changed without a write.");
  a_spd_read: assert property (running && REG_REQ.rd && REG_REQ.addr == REG_CTRL
                               |=> REG_RDATA[SPD_BIT] == $past(SPEED_100))
    else $error("Speed select read back wrong.");

  // Station address.
  a_addr_latch: assert property (r_reg.st == ST_CAPTURE
                                 |=> MGMT_ADDR[2:0] == $past(STRAP_I[PIN_AD0 +: 3]))
    else $error("Address straps not latched.");
  a_addr_upper: assert property (MGMT_ADDR[ADDR_W-1:3] == ADDR_HI)
    else $error("Upper address bits not zero.");
  a_strap_read: assert property (running && REG_REQ.rd && REG_REQ.addr == REG_STRAP
                                 |=> REG_RDATA[ADDR_W-1:0] == $past(MGMT_ADDR)
                                 && REG_RDATA[STRAP_IF_LO +: 3] == $past(r_reg.ifsel))
    else $error("Strap status read back wrong.");

  // Indicator mode field and the pin level it selects.
  a_mode_write: assert property (running && REG_REQ.wr && REG_REQ.addr == REG_IND
                                 |=> r_reg.mode == $past(REG_REQ.wdata[IND_LO +: 2]))
    else $error("Indicator mode write lost.");
  a_mode_keep: assert property (running && !(REG_REQ.wr && REG_REQ.addr == REG_IND)
                                |=> $stable(r_reg.mode))
    else $error("Indicator mode changed without a write.");
  a_mode_read: assert property (running && REG_REQ.rd && REG_REQ.addr == REG_IND
                                |=> REG_RDATA[IND_LO +: 2] == $past(r_reg.mode))
    else $error("Indicator mode read back wrong.");
  a_led_speed: assert property (running && r_reg.mode == IND_SPEED
                                |=> STRAP_O[PIN_SPD] == !$past(r_reg.spd))
    else $error("Speed indicator wrong in mode 00.");
  a_led_idle: assert property (running && r_reg.mode == IND_ACT && !ACTIVITY
                               |=> STRAP_O[PIN_SPD])
    else $error("Indicator not high without activity.");
  a_led_act: assert property (running && r_reg.mode == IND_ACT && ACTIVITY
                              |=> STRAP_O[PIN_SPD] == $past(r_reg.blink))
    else $error("Indicator does not follow the blink phase.");
  a_led_rsvd: assert property (running && r_reg.mode[1] |=> STRAP_O[PIN_SPD])
    else $error("Reserved mode indicator not high.");

  // Blink phase: a full half period always follows the start of activity.
  a_blink_idle: assert property (!ACTIVITY |=> r_reg.cnt == '0 && r_reg.blink)
    else $error("Blink phase not restarted while idle.");
  a_blink_flip: assert property (ACTIVITY && r_reg.cnt == BLINK_LAST
                                 |=> r_reg.blink != $past(r_reg.blink) && r_reg.cnt == '0)
    else $error("Blink phase did not toggle at the half period.");
  a_blink_step: assert property (ACTIVITY && r_reg.cnt != BLINK_LAST
                                 |=> r_reg.blink == $past(r_reg.blink))
    else $error("Blink phase toggled early.");

  // Interface mode decode of the latched select straps.
  a_if_latch: assert property (r_reg.st == ST_CAPTURE
                               |=> r_reg.ifsel == $past(STRAP_I[PIN_IF0 +: 3]))
    else $error("Interface select straps not latched.");
  a_if_mii: assert property (r_reg.ifsel == IFS_MII |-> IF_MODE.mii && !IF_MODE.reserved)
    else $error("MII decode wrong.");
  a_if_decode: assert property (r_reg.ifsel == IFS_RMII |-> IF_MODE.rmii && !IF_MODE.mii)
    else $error("RMII decode wrong.");
  a_if_pre: assert property (r_reg.ifsel == IFS_MII_PRE
                             |-> IF_MODE.mii_pre && !IF_MODE.reserved)
    else $error("Preamble restore decode wrong.");
  a_if_onehot: assert property ($onehot(IF_MODE))
    else $error("Interface mode decode not one-hot.");

  // Read data is zero outside its one cycle, so a stale word never looks fresh.
  a_rdata_idle: assert property (!REG_REQ.rd |=> REG_RDATA == '0)
    else $error("Read data not cleared after its cycle.");
  a_rd_unmapped: assert property (REG_REQ.rd && REG_REQ.addr != REG_CTRL
                                  && REG_REQ.addr != REG_IND && REG_REQ.addr != REG_STRAP
                                  |=> REG_RDATA == '0)
    else $error("Unmapped read returned nonzero data.");

  c_capture: cover property (r_reg.st == ST_CAPTURE ##1 running);
  c_blink: cover property (running && r_reg.mode == IND_ACT && ACTIVITY ##1 !STRAP_O[PIN_SPD]);
  c_read_ind: cover property (REG_REQ.rd && REG_REQ.addr == REG_IND ##1 REG_RDATA != 16'h0000);
  c_rmii: cover property (running && IF_MODE.rmii);
  c_mode_rsvd: cover property (running && r_reg.mode[1] ##1 STRAP_O[PIN_SPD]);
endmodule : slsl_core

// ---- tb/slsl_board.sv ----
// Board-side strap resistors: a released pin settles to its pull level.
`timescale 1ns/1ps
module slsl_board (
  input wire logic [6:0] pull,   // Pull level fitted on each pin
  input wire logic [6:0] pin_o,  // Device pin output values
  input wire logic [6:0] pin_oe, // Device pin output enables
  output logic [6:0] pin_i       // Resolved pin levels
);
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : pull[i];
    end
  end
endmodule : slsl_board

// ---- tb/slsl_tb_top.sv ----
// Self-checking bench for the strap latch and speed indicator.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module slsl_tb_top import slsl_pkg::*;;
  logic clk, rst_n, activity, speed_100;
  logic [6:0] pull, strap_i, strap_o, strap_oe;
  logic [5:0] func_o;
  logic [15:0] rdata;
  logic [4:0] mgmt_addr;
  logic [2:0] ifs;
  slsl_bus_t req;
  slsl_ifmode_t if_mode, exp_if;
  int error_cnt, n_checks;
  logic [6:0] cases [8] = '{7'h03, 7'h1E, 7'h25, 7'h48, 7'h31, 7'h7F, 7'h5A, 7'h6C};

  slsl_core #(.BLINK_HALF(4)) dut_u (.CLK(clk), .RST_N(rst_n), .STRAP_I(strap_i),
    .STRAP_O(strap_o), .STRAP_OE(strap_oe), .FUNC_O(func_o), .ACTIVITY(activity),
    .REG_REQ(req), .REG_RDATA(rdata), .MGMT_ADDR(mgmt_addr), .IF_MODE(if_mode),
    .SPEED_100(speed_100));
  slsl_board board_u (.pull(pull), .pin_o(strap_o), .pin_oe(strap_oe), .pin_i(strap_i));

  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 `CHK(rdata & m, e)
  endtask : rd_chk

  task automatic boot(input logic [6:0] p);
    @(posedge clk);
    rst_n <= 1'b0;
    pull <= p;
    repeat (20) @(posedge clk);
    #1 `CHK({strap_oe, mgmt_addr, speed_100}, {7'h00, 5'h01, 1'b1})
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : boot

  task automatic wait_led(input logic v);
    int k;
    k = 0;
    while (strap_o[0] !== v && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    if (strap_o[0] !== v) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, strap_o[0], v);
      wrap_up();
    end
  endtask : wait_led

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    pull = 7'h03;
    func_o = 6'h15;
    activity = 1'b0;
    req = '0;
    error_cnt = 0;
    n_checks = 0;
    boot(7'h03);
    `CHK({mgmt_addr, strap_o[0]}, {5'h01, 1'b0})
    wr(REG_CTRL, 16'h0000);
    `CHK({speed_100, strap_o[0]}, 2'b01)
    rd_chk(REG_CTRL, 16'h2000, 16'h0000);
    wr(REG_CTRL, 16'h2000);
    for (int m = 2; m < 4; m++) begin
      wr(REG_IND, {m[1:0], 14'h0000});
      `CHK(strap_o[0], 1'b1)
    end
    wr(REG_IND, 16'h4000);
    rd_chk(REG_IND, 16'hC000, 16'h4000);
    `CHK(strap_o[0], 1'b1)
    rd_chk(5'h05, 16'hFFFF, 16'h0000);
    @(posedge clk);
    activity <= 1'b1;
    wait_led(1'b0);
    repeat (3) @(posedge clk);
    #1 `CHK(strap_o[0], 1'b0)
    @(posedge clk);
    #1 `CHK(strap_o[0], 1'b1)
    @(posedge clk);
    activity <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(strap_o[0], 1'b1)
    for (int i = 0; i < 8; i++) begin
      boot(cases[i]);
      ifs = cases[i][6:4];
      exp_if = '{mii: ifs == 3'h0, rmii: ifs == 3'h1, mii_pre: ifs == 3'h4,
        reserved: !(ifs == 3'h0 || ifs == 3'h1 || ifs == 3'h4)};
      `CHK({mgmt_addr, speed_100}, {2'b00, cases[i][3:1], cases[i][0]})
      `CHK(if_mode, exp_if)
      `CHK({strap_oe, strap_o[6:1]}, {7'h7F, func_o})
      rd_chk(REG_STRAP, 16'h071F, {5'h00, ifs, 3'h0, 2'b00, cases[i][3:1]});
    end
    wrap_up();
  end
endmodule : slsl_tb_top
